// >>> common/cfl_pkg.sv
/*
 * cfl_pkg: register offsets, field positions, reset values, codes,
 * timing counts and state type of the charger fault logic.
 * assumes a 20 MHz system clock.
 */
package cfl_pkg;

   // register offsets
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h01;
   localparam logic [7:0] ADDR_VOLT   = 8'h02;
   localparam logic [7:0] ADDR_IREG   = 8'h04;
   localparam logic [7:0] ADDR_VLOOP  = 8'h05;
   localparam logic [7:0] ADDR_CEIL   = 8'h06;

   // field positions
   localparam int LOOP_ACT_BIT = 4;
   localparam int HOLD_LSB     = 0;
   localparam int FLOAT_LSB    = 2;
   localparam int ICHG_LSB     = 4;
   localparam int ICEIL_LSB    = 4;
   localparam int VCEIL_LSB    = 0;
   localparam int STAT_LSB     = 4;
   localparam int INLIM_LSB    = 6;

   // values after reset
   localparam logic [7:0] RST_CTRL  = 8'h00;
   localparam logic [7:0] RST_VOLT  = 8'h00;
   localparam logic [7:0] RST_IREG  = 8'h00;
   localparam logic [7:0] RST_VLOOP = 8'h00;
   localparam logic [7:0] RST_CEIL  = 8'h00;

   // encodings
   localparam logic [5:0] VCEIL_BASE    = 6'h23;
   localparam logic [2:0] FOLDBACK_CODE = 3'h0;
   localparam logic [2:0] FAULT_NONE    = 3'h0;
   localparam logic [2:0] FAULT_OVP     = 3'h1;
   localparam logic [2:0] FAULT_SLEEP   = 3'h2;
   localparam logic [2:0] FAULT_POOR    = 3'h3;
   localparam logic [2:0] FAULT_THERM   = 3'h5;
   localparam logic [1:0] STAT_READY    = 2'h0;
   localparam logic [1:0] STAT_CHARGING = 2'h1;
   localparam logic [1:0] STAT_FAULT    = 2'h3;

   // timing
   localparam int CLK_KHZ   = 20000;
   localparam int PULSE_US  = 128;
   localparam int PULSE_CYC = PULSE_US * CLK_KHZ / 1000;
   localparam int VALID_MS  = 30;
   localparam int VALID_CYC = VALID_MS * CLK_KHZ;
   localparam int RETRY_MS  = 2000;
   localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
   localparam int RAMP_US   = 100;
   localparam int RAMP_CYC  = RAMP_US * CLK_KHZ / 1000;
   localparam int CNT_W     = 26;
   localparam int PCNT_W    = 12;

   typedef enum logic [2:0] {
      ST_VALIDATE,
      ST_CHARGE,
      ST_SLEEP,
      ST_UV_RETRY,
      ST_OVP
   } cfl_state_t;

endpackage

// >>> rtl/cfl_sync.sv
/*
 * cfl_sync: two-flop synchroniser, one lane per bit.
 * assumes inputs are asynchronous levels from comparators.
 */
module cfl_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta;

   generate
      if (WIDTH < 1)
      begin : g_chk
         $error("cfl_sync width must be at least one");
      end
      for (genvar b = 0; b < WIDTH; b++)
      begin : g_lane
         always_ff @(posedge i_clock)
         begin
            if (i_srst)
            begin
               meta[b]   <= 1'b0;
               o_sync[b] <= 1'b0;
            end
            else
            begin
               meta[b]   <= i_async[b];
               o_sync[b] <= meta[b];
            end
         end
      end
   endgenerate

endmodule // cfl_sync

// >>> rtl/cfl_charger_ctrl.sv
/*
 * cfl_charger_ctrl: charger control and safety fault logic with its
 * register port (byte registers behind the serial host link).
 * assumes comparator flags arrive asynchronously from the power stage
 * and the register port is driven on I_CLOCK.
 */
//
// Contract
// - ramp current until limit, code or hold
// - loop-active bit shows hold loop limiting
// - hold level field selects eight thresholds
// - ceiling loads default above short, writable
// - other write locks ceiling until short
// - over-ceiling charge codes stored as ceiling
// - current ceiling in bits six to four
// - voltage ceiling gives base plus code
// - foldback limits current to foldback code
// - thermal shutdown suspends, fault, pulse
// - thermal suspend freezes timers, then resumes
// - sleep blocks reverse current from battery
// - under-voltage stops charge, fault, pulse
// - retry delay then restart if input good
// - over-voltage while validating or charging opens switch, fault, pulse
// - over-voltage clear resumes after revalidation
// - fault pulses status output fixed time
// - charge starts after validation interval
module cfl_charger_ctrl #(
   parameter int unsigned VALID_CYC = cfl_pkg::VALID_CYC,
   parameter int unsigned RETRY_CYC = cfl_pkg::RETRY_CYC
) (
   input  wire logic       I_CLOCK,
   input  wire logic       I_SRST,
   input  wire logic       I_REG_WR,
   input  wire logic [7:0] I_REG_ADDR,
   input  wire logic [7:0] I_REG_WDATA,
   input  wire logic       I_VBUS_ABOVE_MIN1,
   input  wire logic       I_VBUS_BELOW_MIN2,
   input  wire logic       I_INPUT_OVERVOLTAGE,
   input  wire logic       I_VBUS_BELOW_SLEEP,
   input  wire logic       I_VBUS_AT_HOLD,
   input  wire logic       I_INPUT_LIMIT_HIT,
   input  wire logic       I_VBAT_ABOVE_SHORT,
   input  wire logic       I_THERMAL_FOLDBACK,
   input  wire logic       I_THERMAL_SHUTDOWN,
   output logic [7:0]      O_REG_RDATA,
   output logic            O_CHARGE_EN,
   output logic [2:0]      O_CHARGE_CURRENT_CODE,
   output logic [5:0]      O_FLOAT_VOLTAGE_CODE,
   output logic [1:0]      O_INPUT_CURRENT_CODE,
   output logic [2:0]      O_VBUS_HOLD_LEVEL,
   output logic            O_INPUT_SWITCH_ON,
   output logic            O_REVERSE_BLOCK,
   output logic [2:0]      O_FAULT_CODE,
   output logic [1:0]      O_STAT_BITS,
   output logic            O_STAT_PULSE
);
   import cfl_pkg::*;

   typedef struct packed {
      cfl_state_t         st;
      logic [CNT_W-1:0]   tmr;
      logic [PCNT_W-1:0]  pcnt;
      logic [PCNT_W-1:0]  rcnt;
      logic [2:0]         level;
      logic [2:0]         fault;
      logic [7:0]         ctrl;
      logic [7:0]         volt;
      logic [7:0]         ireg;
      logic [7:0]         vloop;
      logic [7:0]         ceil;
      logic               unlocked;
      logic               short_d;
      logic               therm;
      logic [7:0]         rdata;
   } cfl_regs_t;

   cfl_regs_t s;
   cfl_regs_t next_s;

   logic [8:0] flags;
   logic       above_min1;
   logic       below_min2;
   logic       ovp;
   logic       below_sleep;
   logic       at_hold;
   logic       ilim_hit;
   logic       above_short;
   logic       foldback;
   logic       shutdown;
   logic [5:0] vmax;
   logic [2:0] imax;
   logic [2:0] target;
   logic       charging;
   logic [1:0] stat;

   generate
      if (VALID_CYC < 1 || VALID_CYC >= 2 ** CNT_W)
      begin : g_chk_valid
         $error("VALID_CYC out of range");
      end
      if (RETRY_CYC < 1 || RETRY_CYC >= 2 ** CNT_W)
      begin : g_chk_retry
         $error("RETRY_CYC out of range");
      end
   endgenerate

   cfl_sync #(
      .WIDTH (9)
   ) u_sync (
      .i_clock (I_CLOCK),
      .i_srst  (I_SRST),
      .i_async ({I_VBUS_ABOVE_MIN1, I_VBUS_BELOW_MIN2, I_INPUT_OVERVOLTAGE,
                 I_VBUS_BELOW_SLEEP, I_VBUS_AT_HOLD, I_INPUT_LIMIT_HIT,
                 I_VBAT_ABOVE_SHORT, I_THERMAL_FOLDBACK,
                 I_THERMAL_SHUTDOWN}),
      .o_sync  (flags)
   );

   assign {above_min1, below_min2, ovp, below_sleep, at_hold, ilim_hit,
           above_short, foldback, shutdown} = flags;

   // ceiling decode
   assign vmax = VCEIL_BASE + {2'h0, s.ceil[VCEIL_LSB +: 4]};
   assign imax = s.ceil[ICEIL_LSB +: 3];
   assign target = foldback ? FOLDBACK_CODE : s.ireg[ICHG_LSB +: 3];
   assign charging = (s.st == ST_CHARGE) && !s.therm;

   always_comb
   begin
      if (s.fault != FAULT_NONE)
      begin
         stat = STAT_FAULT;
      end
      else if (charging)
      begin
         stat = STAT_CHARGING;
      end
      else
      begin
         stat = STAT_READY;
      end
   end

   always_comb
   begin
      next_s = s;
      next_s.short_d = above_short;
      next_s.therm = shutdown;
      if (s.pcnt != '0)
      begin
         next_s.pcnt = s.pcnt - 1'b1;
      end

      // register writes
      if (I_REG_WR)
      begin
         case (I_REG_ADDR)
            ADDR_CTRL:
            begin
               next_s.ctrl = I_REG_WDATA;
            end
            ADDR_VOLT:
            begin
               next_s.volt = I_REG_WDATA;
               if (I_REG_WDATA[FLOAT_LSB +: 6] > vmax)
               begin
                  next_s.volt[FLOAT_LSB +: 6] = vmax;
               end
            end
            ADDR_IREG:
            begin
               next_s.ireg = I_REG_WDATA;
               if (I_REG_WDATA[ICHG_LSB +: 3] > imax)
               begin
                  next_s.ireg[ICHG_LSB +: 3] = imax;
               end
            end
            ADDR_VLOOP:
            begin
               next_s.vloop = I_REG_WDATA;
            end
            default:
            begin
            end
         endcase
         if (I_REG_ADDR == ADDR_CEIL)
         begin
            if (s.unlocked)
            begin
               next_s.ceil = I_REG_WDATA;
            end
         end
         else
         begin
            next_s.unlocked = 1'b0;
         end
      end
      if (above_short && !s.short_d)
      begin
         next_s.ceil = RST_CEIL;
         next_s.unlocked = 1'b1;
      end
      else if (!above_short)
      begin
         next_s.unlocked = 1'b1;
      end

      // thermal shutdown: suspend, freeze timers, keep state
      if (shutdown)
      begin
         if (!s.therm)
         begin
            next_s.fault = FAULT_THERM;
            next_s.pcnt = PCNT_W'(PULSE_CYC);
         end
      end
      else if (s.therm)
      begin
         next_s.fault = FAULT_NONE;
      end
      else
      begin
         case (s.st)
            ST_VALIDATE:
            begin
               if (ovp)
               begin
                  next_s.st = ST_OVP;
                  next_s.fault = FAULT_OVP;
                  next_s.pcnt = PCNT_W'(PULSE_CYC);
               end
               else if (!above_min1)
               begin
                  next_s.tmr = '0;
               end
               else if (s.tmr == CNT_W'(VALID_CYC - 1))
               begin
                  next_s.st = ST_CHARGE;
                  next_s.tmr = '0;
                  next_s.level = '0;
                  next_s.rcnt = '0;
                  next_s.fault = FAULT_NONE;
               end
               else
               begin
                  next_s.tmr = s.tmr + 1'b1;
               end
            end
            ST_CHARGE:
            begin
               if (ovp)
               begin
                  next_s.st = ST_OVP;
                  next_s.fault = FAULT_OVP;
                  next_s.pcnt = PCNT_W'(PULSE_CYC);
               end
               else if (below_min2)
               begin
                  next_s.st = ST_UV_RETRY;
                  next_s.fault = FAULT_POOR;
                  next_s.pcnt = PCNT_W'(PULSE_CYC);
               end
               else if (below_sleep && above_min1)
               begin
                  next_s.st = ST_SLEEP;
                  next_s.fault = FAULT_SLEEP;
                  next_s.pcnt = PCNT_W'(PULSE_CYC);
               end
               else if (s.level > target)
               begin
                  next_s.level = target;
               end
               else if (s.level < target && !ilim_hit && !at_hold)
               begin
                  if (s.rcnt == PCNT_W'(RAMP_CYC - 1))
                  begin
                     next_s.rcnt = '0;
                     next_s.level = s.level + 1'b1;
                  end
                  else
                  begin
                     next_s.rcnt = s.rcnt + 1'b1;
                  end
               end
            end
            ST_SLEEP:
            begin
               if (!below_sleep || !above_min1)
               begin
                  next_s.st = ST_VALIDATE;
                  next_s.tmr = '0;
                  next_s.fault = FAULT_NONE;
               end
            end
            ST_UV_RETRY:
            begin
               if (s.tmr == CNT_W'(RETRY_CYC - 1))
               begin
                  next_s.tmr = '0;
                  if (above_min1)
                  begin
                     next_s.st = ST_VALIDATE;
                     next_s.fault = FAULT_NONE;
                  end
               end
               else
               begin
                  next_s.tmr = s.tmr + 1'b1;
               end
            end
            ST_OVP:
            begin
               if (!ovp)
               begin
                  next_s.st = ST_VALIDATE;
                  next_s.tmr = '0;
                  next_s.fault = FAULT_NONE;
               end
            end
            default:
            begin
               next_s.st = ST_VALIDATE;
            end
         endcase
      end

      // registered read data
      case (I_REG_ADDR)
         ADDR_STATUS:
         begin
            next_s.rdata = {2'h0, stat, 1'b0, s.fault};
         end
         ADDR_CTRL:
         begin
            next_s.rdata = s.ctrl;
         end
         ADDR_VOLT:
         begin
            next_s.rdata = s.volt;
         end
         ADDR_IREG:
         begin
            next_s.rdata = s.ireg;
         end
         ADDR_VLOOP:
         begin
            next_s.rdata = s.vloop;
            next_s.rdata[LOOP_ACT_BIT] = charging && at_hold;
         end
         ADDR_CEIL:
         begin
            next_s.rdata = s.ceil;
         end
         default:
         begin
            next_s.rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         s.st       <= ST_VALIDATE;
         s.tmr      <= '0;
         s.pcnt     <= '0;
         s.rcnt     <= '0;
         s.level    <= '0;
         s.fault    <= FAULT_NONE;
         s.ctrl     <= RST_CTRL;
         s.volt     <= RST_VOLT;
         s.ireg     <= RST_IREG;
         s.vloop    <= RST_VLOOP;
         s.ceil     <= RST_CEIL;
         s.unlocked <= 1'b1;
         s.short_d  <= 1'b0;
         s.therm    <= 1'b0;
         s.rdata    <= 8'h00;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign O_REG_RDATA           = s.rdata;
   assign O_CHARGE_EN           = charging;
   assign O_CHARGE_CURRENT_CODE = s.level;
   assign O_FLOAT_VOLTAGE_CODE  = s.volt[FLOAT_LSB +: 6];
   assign O_INPUT_CURRENT_CODE  = s.ctrl[INLIM_LSB +: 2];
   assign O_VBUS_HOLD_LEVEL     = s.vloop[HOLD_LSB +: 3];
   assign O_INPUT_SWITCH_ON     = (s.st != ST_OVP);
   assign O_REVERSE_BLOCK       = (s.st == ST_SLEEP);
   assign O_FAULT_CODE          = s.fault;
   assign O_STAT_BITS           = stat;
   assign O_STAT_PULSE          = (s.pcnt != '0);

endmodule // cfl_charger_ctrl

// >>> dv/cfl_charger_ctrl_properties.sv
/* cfl_charger_ctrl_properties: timing checks on the charger fault logic.
   assumes it is bound to the top module and sees only its ports. */
module cfl_charger_ctrl_properties (
   input wire logic       I_CLOCK, I_SRST, I_REG_WR,
   input wire logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA,
   input wire logic       I_VBUS_ABOVE_MIN1, I_VBUS_BELOW_MIN2, I_INPUT_OVERVOLTAGE,
   input wire logic       I_VBUS_BELOW_SLEEP, I_VBUS_AT_HOLD,
   input wire logic       I_INPUT_LIMIT_HIT, I_VBAT_ABOVE_SHORT,
   input wire logic       I_THERMAL_FOLDBACK, I_THERMAL_SHUTDOWN,
   input wire logic       O_CHARGE_EN, O_INPUT_SWITCH_ON, O_REVERSE_BLOCK,
   input wire logic       O_STAT_PULSE,
   input wire logic [2:0] O_CHARGE_CURRENT_CODE, O_VBUS_HOLD_LEVEL,
   input wire logic [2:0] O_FAULT_CODE,
   input wire logic [5:0] O_FLOAT_VOLTAGE_CODE,
   input wire logic [1:0] O_INPUT_CURRENT_CODE, O_STAT_BITS
);
   timeunit 1ns;
   timeprecision 1ns;
   import cfl_pkg::*;
   logic [PCNT_W-1:0] pcnt;
   logic [2:0]        fault_d;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);
   // counts pulse cycles since the latest fault event, which restarts it
   always_ff @(posedge I_CLOCK)
   begin
      fault_d <= O_FAULT_CODE;
      if (I_SRST || !O_STAT_PULSE)
         pcnt <= '0;
      else if (O_FAULT_CODE != fault_d && O_FAULT_CODE != FAULT_NONE)
         pcnt <= PCNT_W'(1);
      else
         pcnt <= pcnt + 1'b1;
   end
   a_pulse_len: assert property ($fell(O_STAT_PULSE) |-> pcnt == PULSE_CYC)
      else $error("status pulse length wrong");
   a_pulse_max: assert property (pcnt <= PULSE_CYC)
      else $error("status pulse too long");
   a_ovp_fault: assert property ($rose(I_INPUT_OVERVOLTAGE) ##1 I_INPUT_OVERVOLTAGE[*2] |=>
      O_FAULT_CODE == FAULT_OVP && O_STAT_BITS == STAT_FAULT && O_STAT_PULSE)
      else $error("over-voltage not reported");
   a_ovp_switch: assert property (!O_INPUT_SWITCH_ON |-> O_FAULT_CODE == FAULT_OVP)
      else $error("input switch open without over-voltage");
   a_therm_fault: assert property ($rose(I_THERMAL_SHUTDOWN) ##1
      I_THERMAL_SHUTDOWN[*2] |=> O_FAULT_CODE == FAULT_THERM && !O_CHARGE_EN)
      else $error("thermal shutdown not handled");
   a_uv_fault: assert property ($rose(I_VBUS_BELOW_MIN2) && O_CHARGE_EN ##1
      I_VBUS_BELOW_MIN2[*2] |=> O_FAULT_CODE == FAULT_POOR && !O_CHARGE_EN)
      else $error("under-voltage not handled");
   a_sleep_block: assert property ($rose(I_VBUS_BELOW_SLEEP) ##1
      (I_VBUS_BELOW_SLEEP && I_VBUS_ABOVE_MIN1)[*2] |=> O_REVERSE_BLOCK)
      else $error("sleep does not block reverse current");
   a_stat_fault: assert property (O_FAULT_CODE != FAULT_NONE |->
      O_STAT_BITS == STAT_FAULT) else $error("status bits miss fault");
   a_charge_clean: assert property (O_CHARGE_EN |-> O_INPUT_SWITCH_ON
      && O_FAULT_CODE == FAULT_NONE) else $error("charging during fault");
   a_fold_limit: assert property (I_THERMAL_FOLDBACK[*4] |->
      O_CHARGE_CURRENT_CODE == FOLDBACK_CODE) else $error("foldback ignored");
   a_hold_level: assert property (I_REG_WR && I_REG_ADDR == ADDR_VLOOP ##1
      !I_REG_WR |=> {5'h0, O_VBUS_HOLD_LEVEL} == ($past(I_REG_WDATA, 2) & 8'h07))
      else $error("hold level not applied");
   c_ovp: cover property (O_FAULT_CODE == FAULT_OVP);
   c_therm: cover property (O_FAULT_CODE == FAULT_THERM);
   c_sleep: cover property (O_REVERSE_BLOCK);
endmodule // cfl_charger_ctrl_properties

bind cfl_charger_ctrl cfl_charger_ctrl_properties props (.*);

// >>> dv/cfl_host_model.sv
/* cfl_host_model: host side of the byte register port.
   assumes its tasks are called just after a falling clock edge. */
module cfl_host_model (
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr = 1'h0,
   output logic [7:0]      o_addr = 8'h00,
   output logic [7:0]      o_wdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic wr(input logic [7:0] a, d);
      o_wr = 1'h1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clock);
      o_wr = 1'h0;
      o_wdata = ~d;
      @(negedge i_clock);
   endtask
   task automatic wr_ceil(input logic [7:0] d);
      wr(cfl_pkg::ADDR_CEIL, d);
      wr(cfl_pkg::ADDR_CEIL, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      o_addr = a;
      repeat (2) @(negedge i_clock);
      d = i_rdata;
   endtask
endmodule // cfl_host_model

// >>> dv/cfl_charger_ctrl_tb.sv
/* cfl_charger_ctrl_tb: self-checking bench of the charger fault logic.
   assumes shortened validation and retry counts. */
module cfl_charger_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cfl_pkg::*;
   localparam int VCYC = 20;
   localparam int RCYC = 30;
   logic I_CLOCK = 1'h0, I_SRST = 1'h1, I_REG_WR;
   logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, c, w, d;
   logic I_VBUS_ABOVE_MIN1 = 1'h0, I_VBUS_BELOW_MIN2 = 1'h0, I_INPUT_OVERVOLTAGE = 1'h0;
   logic I_VBUS_BELOW_SLEEP = 1'h0, I_VBUS_AT_HOLD = 1'h0;
   logic I_INPUT_LIMIT_HIT = 1'h0, I_VBAT_ABOVE_SHORT = 1'h0;
   logic I_THERMAL_FOLDBACK = 1'h0, I_THERMAL_SHUTDOWN = 1'h0;
   logic O_CHARGE_EN, O_INPUT_SWITCH_ON, O_REVERSE_BLOCK, O_STAT_PULSE;
   logic [2:0] O_CHARGE_CURRENT_CODE, O_VBUS_HOLD_LEVEL, O_FAULT_CODE;
   logic [5:0] O_FLOAT_VOLTAGE_CODE, e;
   logic [1:0] O_INPUT_CURRENT_CODE, O_STAT_BITS;
   int fails = 0;
   int comparisons = 0;
   int seed;
   always #25 I_CLOCK = ~I_CLOCK;
   cfl_charger_ctrl #(.VALID_CYC(VCYC), .RETRY_CYC(RCYC)) dut (.*);
   cfl_host_model host (.i_clock(I_CLOCK), .i_rdata(O_REG_RDATA),
      .o_wr(I_REG_WR), .o_addr(I_REG_ADDR), .o_wdata(I_REG_WDATA));
   function automatic logic [5:0] cmin(input logic [5:0] a, b);
      return (a > b) ? b : a;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge I_CLOCK);
   endtask
   task automatic chk(input string n, input logic [7:0] s, x);
      comparisons++;
      if (s !== x)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic results;
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic unlock;
      I_VBAT_ABOVE_SHORT = 1'h0;
      cyc(4);
      I_VBAT_ABOVE_SHORT = 1'h1;
      cyc(4);
   endtask
   initial
   begin
      repeat (100000) @(posedge I_CLOCK);
      fails++;
      results();
   end
   initial
   begin
      seed = 67318;
      cyc(6);
      I_SRST = 1'h0;
      host.rd(ADDR_VLOOP, d);
      chk("vloop_rst", d, RST_VLOOP);
      host.rd(8'h03, d);
      chk("unmapped", d, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         unlock();
         host.rd(ADDR_CEIL, d);
         chk("ceil_dflt", d, RST_CEIL);
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed)) & 8'h7f;
         host.wr_ceil(c);
         host.rd(ADDR_CEIL, d);
         chk("ceil", d, c);
         w = (i < 2) ? 8'hff : 8'($random(seed));
         host.wr(ADDR_IREG, w);
         host.rd(ADDR_IREG, d);
         e = cmin(6'(w[6:4]), 6'(c[6:4]));
         chk("ichg", 8'(d[6:4]), 8'(e));
         w = (i < 2) ? 8'hff : 8'($random(seed));
         host.wr(ADDR_VOLT, w);
         host.rd(ADDR_VOLT, d);
         e = cmin(w[7:2], VCEIL_BASE + 6'(c[3:0]));
         chk("float_voltage_code", 8'(d[7:2]), 8'(e));
         chk("float_voltage_code_pin", 8'(O_FLOAT_VOLTAGE_CODE), 8'(e));
         host.wr_ceil(~c & 8'h7f);
         host.rd(ADDR_CEIL, d);
         chk("ceil_lock", d, c);
      end
      unlock();
      host.wr_ceil(8'h7f);
      host.wr(ADDR_IREG, 8'h20);
      w = 8'($random(seed));
      host.wr(ADDR_VLOOP, w);
      cyc(2);
      chk("hold_lvl", 8'(O_VBUS_HOLD_LEVEL), w & 8'h07);
      w = 8'($random(seed));
      host.wr(ADDR_CTRL, w);
      host.rd(ADDR_CTRL, d);
      chk("ctrl", d, w);
      chk("inlim", 8'(O_INPUT_CURRENT_CODE), 8'(w[7:6]));
      I_VBUS_ABOVE_MIN1 = 1'h1;
      cyc(VCYC - 2);
      chk("early", 8'(O_CHARGE_EN), 8'h00);
      cyc(8);
      chk("chg_on", 8'(O_CHARGE_EN), 8'h01);
      cyc(4500);
      chk("ramp", 8'(O_CHARGE_CURRENT_CODE), 8'h02);
      I_VBUS_AT_HOLD = 1'h1;
      cyc(4);
      host.rd(ADDR_VLOOP, d);
      chk("loop_on", 8'(d[4]), 8'h01);
      I_VBUS_AT_HOLD = 1'h0;
      I_THERMAL_FOLDBACK = 1'h1;
      cyc(4);
      host.rd(ADDR_VLOOP, d);
      chk("loop_off", 8'(d[4]), 8'h00);
      chk("fold", 8'(O_CHARGE_CURRENT_CODE), 8'(FOLDBACK_CODE));
      I_THERMAL_FOLDBACK = 1'h0;
      I_THERMAL_SHUTDOWN = 1'h1;
      cyc(4);
      chk("therm", 8'(O_FAULT_CODE), 8'(FAULT_THERM));
      chk("therm_off", 8'(O_CHARGE_EN), 8'h00);
      I_THERMAL_SHUTDOWN = 1'h0;
      cyc(4);
      chk("cool", 8'({O_CHARGE_EN, O_FAULT_CODE}), 8'h08);
      cyc(2600);
      chk("pulse_end", 8'(O_STAT_PULSE), 8'h00);
      I_INPUT_OVERVOLTAGE = 1'h1;
      cyc(4);
      chk("ovp", 8'({O_INPUT_SWITCH_ON, O_STAT_BITS, O_FAULT_CODE}), 8'h19);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h31);
      I_INPUT_OVERVOLTAGE = 1'h0;
      cyc(4);
      chk("ovp_clr", 8'({O_CHARGE_EN, O_FAULT_CODE}), 8'h00);
      cyc(VCYC + 6);
      chk("ovp_back", 8'(O_CHARGE_EN), 8'h01);
      I_INPUT_LIMIT_HIT = 1'h1;
      cyc(2600);
      chk("ilim_stop", 8'(O_CHARGE_CURRENT_CODE), 8'h00);
      I_INPUT_LIMIT_HIT = 1'h0;
      I_VBUS_BELOW_MIN2 = 1'h1;
      I_VBUS_ABOVE_MIN1 = 1'h0;
      cyc(4);
      chk("uv", 8'({O_CHARGE_EN, O_STAT_BITS, O_FAULT_CODE}), 8'h1b);
      I_VBUS_BELOW_MIN2 = 1'h0;
      I_VBUS_ABOVE_MIN1 = 1'h1;
      cyc(RCYC / 2);
      chk("uv_wait", 8'(O_CHARGE_EN), 8'h00);
      cyc(RCYC + VCYC + 10);
      chk("uv_retry", 8'(O_CHARGE_EN), 8'h01);
      cyc(2600);
      I_VBUS_BELOW_SLEEP = 1'h1;
      cyc(4);
      chk("sleep", 8'({O_REVERSE_BLOCK, O_CHARGE_EN}), 8'h02);
      cyc(2600);
      results();
   end
endmodule // cfl_charger_ctrl_tb
